//--- core/haptic_cal_defines.svh
`ifndef HAPTIC_CAL_DEFINES_SVH
`define HAPTIC_CAL_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_RATED_LEVEL 8'h16
`define OFS_CLAMP_LEVEL 8'h17
`define OFS_CAL_COMP 8'h18
`define OFS_CAL_BEMF 8'h19
`define OFS_FB_CONTROL 8'h1A

// ****************************************************************
// reset values
// ****************************************************************
`define RST_RATED_LEVEL 8'h3F
`define RST_CLAMP_LEVEL 8'h89
`define RST_CAL_COMP 8'h0D
`define RST_CAL_BEMF 8'h6D
`define RST_ACT_TYPE 1'b0

// ****************************************************************
// field positions and scale figures
// ****************************************************************
`define FB_ACT_TYPE_BIT 7
`define SCALE_DIVISOR 16'h00FF
`define BEMF_FULL_MV 20'h0_04C4

`endif

//--- core/haptic_cal_pkg.sv
package haptic_cal_pkg;

   typedef logic [7:0] reg_byte_t;
   typedef logic [7:0] reg_addr_t;

   typedef enum logic {
      ACT_ROTATING_MASS,
      ACT_LINEAR_RESONANT
   } actuator_type_e;

endpackage

//--- core/cal_reg8.sv
`timescale 1ns/1ps

// ****************************************************************
// byte register with a software port and a hardware result port
// ****************************************************************
module cal_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic sw_we,
   input wire logic [7:0] sw_d,
   input wire logic hw_we,
   input wire logic [7:0] hw_d,
   output logic [7:0] q
);

   logic [7:0] q_nxt;

   // hardware result wins a same-cycle collision: the fresh result
   // is the newer measurement
   assign q_nxt = hw_we ? hw_d : (sw_we ? sw_d : q);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= RESET_VALUE;
      end else if (ce) begin
         q <= q_nxt;
      end
   end

endmodule // cal_reg8

//--- core/haptic_cal_feedback_regs.sv
`timescale 1ns/1ps
`include "haptic_cal_defines.svh"

module haptic_cal_feedback_regs (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // register port from the serial bus decoder
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   // calibration engine results
   input wire logic cal_done,
   input wire logic [7:0] cal_comp_in,
   input wire logic [7:0] cal_bemf_in,
   // drive engine side
   input wire logic closed_loop,
   input wire logic overdrive_active,
   input wire logic [7:0] drive_level_in,
   input wire logic [7:0] drive_gain_in,
   input wire logic [1:0] back_emf_scale_select,
   output logic [7:0] drive_level_out_r,
   output logic [7:0] full_scale_ref_r,
   output logic [8:0] comp_gain_out_r,
   output logic [10:0] feedback_ref_mv_r,
   output logic [7:0] rated_level_r,
   output logic actuator_type_select_r
);

   // ****************************************************************
   // address decode
   // ****************************************************************
   wire logic hit_rated;
   wire logic hit_clamp;
   wire logic hit_comp;
   wire logic hit_bemf;
   wire logic hit_fb;

   assign hit_rated = reg_addr == `OFS_RATED_LEVEL;
   assign hit_clamp = reg_addr == `OFS_CLAMP_LEVEL;
   assign hit_comp = reg_addr == `OFS_CAL_COMP;
   assign hit_bemf = reg_addr == `OFS_CAL_BEMF;
   assign hit_fb = reg_addr == `OFS_FB_CONTROL;

   // ****************************************************************
   // storage
   // ****************************************************************
   haptic_cal_pkg::reg_byte_t rated_q;
   haptic_cal_pkg::reg_byte_t clamp_q;
   haptic_cal_pkg::reg_byte_t comp_q;
   haptic_cal_pkg::reg_byte_t bemf_q;
   haptic_cal_pkg::actuator_type_e act_type_r;

   cal_reg8 #(.RESET_VALUE(`RST_RATED_LEVEL)) u_rated (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .sw_we(reg_wr_en && hit_rated),
      .sw_d(reg_wdata),
      .hw_we(1'b0),
      .hw_d(8'h00),
      .q(rated_q)
   );

   cal_reg8 #(.RESET_VALUE(`RST_CLAMP_LEVEL)) u_clamp (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .sw_we(reg_wr_en && hit_clamp),
      .sw_d(reg_wdata),
      .hw_we(1'b0),
      .hw_d(8'h00),
      .q(clamp_q)
   );

   // software value kept until the next calibration result
   cal_reg8 #(.RESET_VALUE(`RST_CAL_COMP)) u_comp (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .sw_we(reg_wr_en && hit_comp),
      .sw_d(reg_wdata),
      .hw_we(cal_done),
      .hw_d(cal_comp_in),
      .q(comp_q)
   );

   cal_reg8 #(.RESET_VALUE(`RST_CAL_BEMF)) u_bemf (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .sw_we(reg_wr_en && hit_bemf),
      .sw_d(reg_wdata),
      .hw_we(cal_done),
      .hw_d(cal_bemf_in),
      .q(bemf_q)
   );

   wire logic act_type_nxt;

   assign act_type_nxt = (reg_wr_en && hit_fb) ?
      reg_wdata[`FB_ACT_TYPE_BIT] : act_type_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         act_type_r <= haptic_cal_pkg::ACT_ROTATING_MASS;
      end else if (ce) begin
         act_type_r <= haptic_cal_pkg::actuator_type_e'(act_type_nxt);
      end
   end

   // ****************************************************************
   // readback
   // ****************************************************************
   wire logic [7:0] rdata_nxt;
   wire logic [7:0] fb_read;

   // the other feedback fields live elsewhere and read as zero here
   assign fb_read = {act_type_r, 7'h00};
   assign rdata_nxt = hit_rated ? rated_q :
                      hit_clamp ? clamp_q :
                      hit_comp ? comp_q :
                      hit_bemf ? bemf_q :
                      hit_fb ? fb_read : 8'h00;

   // ****************************************************************
   // drive references
   // ****************************************************************
   wire logic [7:0] ref_nxt;
   wire logic [7:0] limit;
   wire logic [7:0] level_nxt;

   // closed loop scales to rated level, open loop to the clamp
   assign ref_nxt = closed_loop ? rated_q : clamp_q;
   // closed-loop overdrive may pass the rated level, never the clamp
   assign limit = (closed_loop && overdrive_active) ? clamp_q :
                  ref_nxt;
   assign level_nxt = (drive_level_in > limit) ? limit :
                      drive_level_in;

   // ****************************************************************
   // compensation and feedback scaling
   // ****************************************************************
   wire logic [15:0] gain_prod;
   wire logic [15:0] gain_extra;
   wire logic [8:0] gain_nxt;
   wire logic [19:0] bemf_prod;
   wire logic [19:0] bemf_mv;
   wire logic [10:0] fb_nxt;

   // constant divide: cheap enough at eight bits, avoids a 1/256 error
   assign gain_prod = {8'h00, drive_gain_in} * {8'h00, comp_q};
   assign gain_extra = gain_prod / `SCALE_DIVISOR;
   assign gain_nxt = {1'b0, drive_gain_in} + gain_extra[8:0];

   assign bemf_prod = {12'h000, bemf_q} * `BEMF_FULL_MV;
   assign bemf_mv = bemf_prod / {4'h0, `SCALE_DIVISOR};
   // scale select divides by a power of two
   assign fb_nxt = bemf_mv[10:0] >> back_emf_scale_select;

   // ****************************************************************
   // output registers
   // ****************************************************************
   // readback lags the address by one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_r <= 8'h00;
      end else if (ce) begin
         reg_rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drive_level_out_r <= 8'h00;
      end else if (ce) begin
         drive_level_out_r <= level_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         full_scale_ref_r <= `RST_RATED_LEVEL;
      end else if (ce) begin
         full_scale_ref_r <= ref_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         comp_gain_out_r <= 9'h000;
      end else if (ce) begin
         comp_gain_out_r <= gain_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         feedback_ref_mv_r <= 11'h000;
      end else if (ce) begin
         feedback_ref_mv_r <= fb_nxt;
      end
   end

   // copy for the calibration routine, same latency as the references
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rated_level_r <= `RST_RATED_LEVEL;
      end else if (ce) begin
         rated_level_r <= rated_q;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         actuator_type_select_r <= `RST_ACT_TYPE;
      end else if (ce) begin
         actuator_type_select_r <= act_type_r;
      end
   end

endmodule // haptic_cal_feedback_regs

//--- tb/haptic_cal_feedback_regs_asserts.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module haptic_cal_feedback_regs_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_r,
   input wire logic cal_done,
   input wire logic [7:0] cal_comp_in,
   input wire logic [7:0] cal_bemf_in,
   input wire logic closed_loop,
   input wire logic overdrive_active,
   input wire logic [7:0] drive_level_in,
   input wire logic [7:0] drive_gain_in,
   input wire logic [1:0] back_emf_scale_select,
   input wire logic [7:0] drive_level_out_r,
   input wire logic [7:0] full_scale_ref_r,
   input wire logic [8:0] comp_gain_out_r,
   input wire logic [10:0] feedback_ref_mv_r,
   input wire logic [7:0] rated_level_r,
   input wire logic actuator_type_select_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_swr;
      ce && reg_wr_en && !cal_done && reg_addr == 8'h18
         ##1 ce && reg_addr == 8'h18;
   endsequence
   sequence s_type_wr;
      ce && reg_wr_en && reg_addr == 8'h1a ##1 ce;
   endsequence
   sequence s_cal;
      ce && cal_done ##1 ce && reg_addr == 8'h18;
   endsequence
   property p_fs_cl;
      ce && closed_loop |=> full_scale_ref_r == rated_level_r;
   endproperty
   a_fs_cl: assert property (p_fs_cl)
      else $error("full scale not rated level");
   property p_lim;
      ce && !(closed_loop && overdrive_active) |=> drive_level_out_r ==
         ($past(drive_level_in) < full_scale_ref_r ?
          $past(drive_level_in) : full_scale_ref_r);
   endproperty
   a_lim: assert property (p_lim)
      else $error("drive not limited by full scale");
   property p_od;
      ce && closed_loop && overdrive_active
         |=> drive_level_out_r <= $past(drive_level_in);
   endproperty
   a_od: assert property (p_od)
      else $error("overdrive output above request");
   property p_gain;
      ce |=> comp_gain_out_r >= {1'b0, $past(drive_gain_in)} &&
         comp_gain_out_r <= {$past(drive_gain_in), 1'b0};
   endproperty
   a_gain: assert property (p_gain)
      else $error("compensated gain out of range");
   property p_fb;
      ce |=> feedback_ref_mv_r <= (11'h04c4 >> $past(back_emf_scale_select));
   endproperty
   a_fb: assert property (p_fb)
      else $error("feedback reference out of range");
   property p_type;
      s_type_wr |=> actuator_type_select_r == $past(reg_wdata[7], 2);
   endproperty
   a_type: assert property (p_type)
      else $error("actuator type not written");
   property p_swr;
      s_swr |=> reg_rdata_r == $past(reg_wdata, 2);
   endproperty
   a_swr: assert property (p_swr)
      else $error("software result write lost");
   property p_cal_comp;
      s_cal |=> reg_rdata_r == $past(cal_comp_in, 2);
   endproperty
   a_cal_comp: assert property (p_cal_comp)
      else $error("compensation result not loaded");
   property p_cal_bemf;
      ce && cal_done ##1 ce && back_emf_scale_select == 2'h0
         |=> feedback_ref_mv_r == 11'($past(cal_bemf_in, 2) * 1220 / 255);
   endproperty
   cal_back_emf_result: assert property (p_cal_bemf)
      else $error("back-emf result not loaded");
endmodule // haptic_cal_feedback_regs_chk

//--- tb/host_model.sv
`timescale 1ns/1ps
// ****
// host byte port
// ****
module host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata_r,
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      // released data must not keep looking valid
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata_r;
   endtask
endmodule // host_model

//--- tb/haptic_cal_feedback_regs_tb.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module haptic_cal_feedback_regs_tb;
   typedef struct packed {
      logic cl;
      logic od;
      logic [7:0] din;
      logic [7:0] gain;
      logic [1:0] sel;
   } row_s;
   row_s rows [5] = '{'{1'b0, 1'b0, 8'hff, 8'hff, 2'h1},
      '{1'b1, 1'b0, 8'hff, 8'h80, 2'h2}, '{1'b1, 1'b1, 8'hff, 8'h01, 2'h3},
      '{1'b0, 1'b1, 8'h40, 8'h00, 2'h1}, '{1'b1, 1'b1, 8'h20, 8'hff, 2'h0}};
   logic [7:0] addrs [6] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h20};
   logic [7:0] rsts [6] = '{8'h3f, 8'h89, 8'h0d, 8'h6d, 8'h00, 8'h00};
   logic [7:0] rated = 8'h3f, clamp = 8'h89, comp = 8'h0d, bemf = 8'h6d;
   logic clk, resetn, ce, cal_done, closed_loop, overdrive_active;
   logic reg_wr_en, actuator_type_select_r;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_r, cal_comp_in, cal_bemf_in;
   logic [7:0] drive_level_in, drive_gain_in, drive_level_out_r, d;
   logic [7:0] full_scale_ref_r, rated_level_r;
   logic [1:0] back_emf_scale_select;
   logic [8:0] comp_gain_out_r;
   logic [10:0] feedback_ref_mv_r;
   int n_mismatch = 0;
   int samples_checked = 0;
   haptic_cal_feedback_regs uut (.*);
   host_model host (.*);
   always #2 clk = ~clk;
   task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic drive(input row_s r);
      int lim;
      int g;
      @(negedge clk);
      closed_loop = r.cl;
      overdrive_active = r.od;
      drive_level_in = r.din;
      drive_gain_in = r.gain;
      back_emf_scale_select = r.sel;
      @(negedge clk);
      lim = (r.cl && !r.od) ? rated : clamp;
      g = r.gain * comp / 255 + r.gain;
      cmp(drive_level_out_r, 11'(r.din < lim ? r.din : lim));
      cmp(full_scale_ref_r, r.cl ? rated : clamp);
      cmp(comp_gain_out_r, 11'(g));
      cmp(feedback_ref_mv_r, 11'((bemf * 1220 / 255) >> r.sel));
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // under a hundred cycles expected; far longer means a hang
   initial begin
      #40000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      ce = 1'b1;
      cal_done = 1'b0;
      cal_comp_in = 8'h33;
      cal_bemf_in = 8'h10;
      closed_loop = 1'b0;
      overdrive_active = 1'b0;
      drive_level_in = 8'h00;
      drive_gain_in = 8'h00;
      back_emf_scale_select = 2'h0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      cmp(full_scale_ref_r, 11'h03f);
      cmp(rated_level_r, 11'h03f);
      cmp(drive_level_out_r, 11'h000);
      cmp(comp_gain_out_r, 11'h000);
      cmp(feedback_ref_mv_r, 11'h000);
      resetn = 1'b1;
      foreach (rows[i]) drive(rows[i]);
      foreach (addrs[i]) begin
         host.rd(addrs[i], d);
         cmp(d, rsts[i]);
      end
      host.wr(8'h1a, 8'hff); // type set before calibration
      host.rd(8'h1a, d);
      cmp(d, 8'h80);
      cmp(actuator_type_select_r, 1'b1);
      host.wr(8'h17, 8'ha0);
      host.wr(8'h18, 8'hff);
      host.wr(8'h19, 8'hff);
      host.wr(8'h16, 8'h60);
      {clamp, comp, bemf, rated} = 32'ha0ff_ff60;
      foreach (rows[i]) drive(rows[i]);
      fork
         host.wr(8'h18, 8'h77);
         begin
            @(negedge clk) cal_done = 1'b1;
            @(negedge clk) cal_done = 1'b0;
         end
      join
      {comp, bemf} = 16'h3310;
      host.rd(8'h18, d);
      cmp(d, comp);
      host.rd(8'h19, d);
      cmp(d, bemf);
      foreach (rows[i]) drive(rows[i]);
      @(negedge clk) resetn = 1'b0;
      @(negedge clk);
      cmp(comp_gain_out_r, 11'h000);
      cmp(full_scale_ref_r, 11'h03f);
      resetn = 1'b1;
      host.rd(8'h17, d);
      cmp(d, 8'h89);
      cmp(actuator_type_select_r, 1'b0);
      host.rd(8'h18, d);
      cmp(d, 8'h0d);
      // a write while the clock enable is low must be swallowed
      @(negedge clk) ce = 1'b0;
      host.wr(8'h17, 8'h11);
      ce = 1'b1;
      host.rd(8'h17, d);
      cmp(d, 8'h89);
      end_of_test();
   end
endmodule // haptic_cal_feedback_regs_tb
bind haptic_cal_feedback_regs haptic_cal_feedback_regs_chk chk (.*);
